/* File: verilog/ufc_frame_counter.sv */
// Frame interval, bit-time down counter and frame sequence counter.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module ufc_frame_counter (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axil_awaddr_i,
    input wire logic s_axil_awvalid_i,
    output logic s_axil_awready_o,
    input wire logic [31:0] s_axil_wdata_i,
    input wire logic [3:0] s_axil_wstrb_i,
    input wire logic s_axil_wvalid_i,
    output logic s_axil_wready_o,
    output logic [1:0] s_axil_bresp_o,
    output logic s_axil_bvalid_o,
    input wire logic s_axil_bready_i,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axil_araddr_i,
    input wire logic s_axil_arvalid_i,
    output logic s_axil_arready_o,
    output logic [31:0] s_axil_rdata_o,
    output logic [1:0] s_axil_rresp_o,
    output logic s_axil_rvalid_o,
    input wire logic s_axil_rready_i,
    // Frame sequencing
    input wire logic xfer_bit_i,
    output logic sof_token_o,
    output logic sca_wr_req_o,
    output logic [15:0] sca_wr_data_o,
    input wire logic sca_wr_ack_i,
    output logic ed_fetch_ok_o,
    output logic [14:0] largest_packet_cnt_o,
    // Interrupt
    output logic irq_o
);

    // ==========================================================
    // Declarations
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_fire;
    logic addr_hit;
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [13:0] sof_period_bits_r;
    logic [14:0] largest_packet_bits_r;
    logic interval_update_toggle_r;
    logic [13:0] bit_times_left_r;
    logic left_count_toggle_copy_r;
    logic [15:0] sof_sequence_count_r;
    logic running_state_r;
    logic run_prev_r;
    logic enter_run;
    logic bit_tick;
    logic reload;
    logic frame_start;
    logic soft_rst_wr;
    logic [ufc_pkg::EVT_W-1:0] evt_set;
    logic [ufc_pkg::EVT_W-1:0] evt_status;
    logic [ufc_pkg::EVT_W-1:0] evt_mask;
    ufc_pkg::ufc_frame_st_t st_r;

    // ==========================================================
    // Submodules
    ufc_bit_tick u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(bit_tick)
    );

    ufc_evt_irq u_evt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(evt_set),
        .clr_we_i(wr_fire && aw_addr_r == ufc_pkg::OFF_EVT && w_strb_r[0]),
        .clr_i(w_data_r[ufc_pkg::EVT_W-1:0]),
        .mask_we_i(wr_fire && aw_addr_r == ufc_pkg::OFF_MASK && w_strb_r[0]),
        .mask_i(w_data_r[ufc_pkg::EVT_W-1:0]),
        .status_o(evt_status),
        .mask_o(evt_mask),
        .irq_o(irq_o)
    );

    // ==========================================================
    // Bus write path
    always_comb begin
        unique case (aw_addr_r)
            ufc_pkg::OFF_PERIOD, ufc_pkg::OFF_LEFT, ufc_pkg::OFF_SEQ,
            ufc_pkg::OFF_EVT, ufc_pkg::OFF_MASK, ufc_pkg::OFF_CTRL: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    assign wr_fire = aw_hold_r && w_hold_r && !s_axil_bvalid_o;
    assign soft_rst_wr = wr_fire && aw_addr_r == ufc_pkg::OFF_CTRL && w_strb_r[0]
                         && w_data_r[ufc_pkg::CTRL_SRST_BIT];
    assign wr_word = ufc_pkg::wmerge({interval_update_toggle_r, largest_packet_bits_r,
                                      2'h0, sof_period_bits_r}, w_data_r, w_strb_r);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
            s_axil_awready_o <= 1'b0;
        end else if (s_axil_awvalid_i && s_axil_awready_o) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= {s_axil_awaddr_i[7:2], 2'h0};
            s_axil_awready_o <= 1'b0;
        end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
            s_axil_awready_o <= 1'b1;
        end else begin
            s_axil_awready_o <= !aw_hold_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            w_hold_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axil_wready_o <= 1'b0;
        end else if (s_axil_wvalid_i && s_axil_wready_o) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axil_wdata_i;
            w_strb_r <= s_axil_wstrb_i;
            s_axil_wready_o <= 1'b0;
        end else if (wr_fire) begin
            w_hold_r <= 1'b0;
            s_axil_wready_o <= 1'b1;
        end else begin
            s_axil_wready_o <= !w_hold_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_axil_bvalid_o <= 1'b0;
            s_axil_bresp_o <= ufc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axil_bvalid_o <= 1'b1;
            s_axil_bresp_o <= addr_hit ? ufc_pkg::RESP_OKAY : ufc_pkg::RESP_SLVERR;
        end else if (s_axil_bready_i) begin
            s_axil_bvalid_o <= 1'b0;
        end
    end

    // ==========================================================
    // Interval configuration and run control
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst_wr) begin
            sof_period_bits_r <= ufc_pkg::PERIOD_RST;
        end else if (wr_fire && aw_addr_r == ufc_pkg::OFF_PERIOD) begin
            sof_period_bits_r <= wr_word[ufc_pkg::PERIOD_W-1:0];
        end
    end

    // The packet budget and toggle survive a soft reset; the interval is nominal again and the run bit clears.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            largest_packet_bits_r <= ufc_pkg::LPKT_RST;
            interval_update_toggle_r <= 1'b0;
        end else if (wr_fire && aw_addr_r == ufc_pkg::OFF_PERIOD) begin
            largest_packet_bits_r <= wr_word[ufc_pkg::LPKT_LSB +: ufc_pkg::LPKT_W];
            interval_update_toggle_r <= wr_word[ufc_pkg::TOGGLE_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst_wr) begin
            running_state_r <= 1'b0;
            run_prev_r <= 1'b0;
        end else begin
            run_prev_r <= running_state_r;
            if (wr_fire && aw_addr_r == ufc_pkg::OFF_CTRL && w_strb_r[0]) begin
                running_state_r <= w_data_r[ufc_pkg::CTRL_RUN_BIT];
            end
        end
    end

    // ==========================================================
    // Bit-time down counter and sequence count
    assign enter_run = running_state_r && !run_prev_r;
    assign reload = bit_tick && running_state_r && bit_times_left_r == 14'h0000;
    assign frame_start = enter_run || reload;

    // Count registers have no write path at all.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_times_left_r <= 14'h0000;
            left_count_toggle_copy_r <= 1'b0;
            sof_sequence_count_r <= 16'h0000;
        end else if (enter_run) begin
            bit_times_left_r <= sof_period_bits_r;
            sof_sequence_count_r <= sof_sequence_count_r + 16'h0001;
        end else if (reload) begin
            bit_times_left_r <= sof_period_bits_r;
            left_count_toggle_copy_r <= interval_update_toggle_r;
            sof_sequence_count_r <= sof_sequence_count_r + 16'h0001;
        end else if (bit_tick && running_state_r) begin
            bit_times_left_r <= bit_times_left_r - 14'h0001;
        end
    end

    // Bit 15 of the count flips here, which lets software keep a longer count.
    assign evt_set[ufc_pkg::EVT_WRAP_BIT] = frame_start && &sof_sequence_count_r[14:0];
    assign evt_set[ufc_pkg::EVT_SOF_BIT] = st_r == ufc_pkg::ST_WR && sca_wr_ack_i;

    // ==========================================================
    // Largest-packet budget
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            largest_packet_cnt_o <= 15'h0000;
        end else if (frame_start) begin
            largest_packet_cnt_o <= largest_packet_bits_r;
        end else if (xfer_bit_i && largest_packet_cnt_o != 15'h0000) begin
            largest_packet_cnt_o <= largest_packet_cnt_o - 15'h0001;
        end
    end

    // ==========================================================
    // Frame start sequence: token, shared-area write, then descriptors
    // A frame start that arrives before the previous write is acknowledged
    // is not sequenced; a frame is thousands of cycles long.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= ufc_pkg::ST_IDLE;
            sof_token_o <= 1'b0;
            sca_wr_req_o <= 1'b0;
            sca_wr_data_o <= 16'h0000;
            ed_fetch_ok_o <= 1'b0;
        end else begin
            unique case (st_r)
                ufc_pkg::ST_IDLE: begin
                    if (frame_start) begin
                        st_r <= ufc_pkg::ST_SOF;
                        sof_token_o <= 1'b1;
                        ed_fetch_ok_o <= 1'b0;
                    end
                end
                ufc_pkg::ST_SOF: begin
                    st_r <= ufc_pkg::ST_WR;
                    sof_token_o <= 1'b0;
                    sca_wr_req_o <= 1'b1;
                    sca_wr_data_o <= sof_sequence_count_r;
                end
                ufc_pkg::ST_WR: begin
                    if (sca_wr_ack_i) begin
                        st_r <= ufc_pkg::ST_IDLE;
                        sca_wr_req_o <= 1'b0;
                        ed_fetch_ok_o <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Bus read path
    always_comb begin
        rd_hit = 1'b1;
        unique case ({s_axil_araddr_i[7:2], 2'h0})
            ufc_pkg::OFF_PERIOD: rd_word = {interval_update_toggle_r, largest_packet_bits_r,
                                            2'h0, sof_period_bits_r};
            ufc_pkg::OFF_LEFT: rd_word = {left_count_toggle_copy_r, 17'h0_0000,
                                          bit_times_left_r};
            ufc_pkg::OFF_SEQ: rd_word = {16'h0000, sof_sequence_count_r};
            ufc_pkg::OFF_EVT: rd_word = {30'h0000_0000, evt_status};
            ufc_pkg::OFF_MASK: rd_word = {30'h0000_0000, evt_mask};
            ufc_pkg::OFF_CTRL: rd_word = {31'h0000_0000, running_state_r};
            default: begin
                rd_word = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_axil_arready_o <= 1'b0;
            s_axil_rvalid_o <= 1'b0;
            s_axil_rdata_o <= 32'h0000_0000;
            s_axil_rresp_o <= ufc_pkg::RESP_OKAY;
        end else if (s_axil_arvalid_i && s_axil_arready_o) begin
            s_axil_arready_o <= 1'b0;
            s_axil_rvalid_o <= 1'b1;
            s_axil_rdata_o <= rd_word;
            s_axil_rresp_o <= rd_hit ? ufc_pkg::RESP_OKAY : ufc_pkg::RESP_SLVERR;
        end else if (s_axil_rvalid_o && s_axil_rready_i) begin
            s_axil_rvalid_o <= 1'b0;
            s_axil_arready_o <= 1'b1;
        end else begin
            s_axil_arready_o <= !s_axil_rvalid_o;
        end
    end

    // ==========================================================
    // Checks
    property p_srst_nominal;
        @(posedge clk_i) disable iff (rst_i)
        soft_rst_wr |=> sof_period_bits_r == ufc_pkg::PERIOD_RST && !running_state_r;
    endproperty
    a_srst_nominal: assert property (p_srst_nominal) else $error("interval not nominal");

    property p_reload;
        @(posedge clk_i) disable iff (rst_i)
        reload && !enter_run |=> bit_times_left_r == $past(sof_period_bits_r);
    endproperty
    a_reload: assert property (p_reload) else $error("down counter reload wrong");

    property p_count_down;
        @(posedge clk_i) disable iff (rst_i)
        bit_tick && running_state_r && !enter_run && bit_times_left_r != 14'h0000
        |=> bit_times_left_r == $past(bit_times_left_r) - 14'h0001;
    endproperty
    a_count_down: assert property (p_count_down) else $error("down count wrong");

    property p_enter;
        @(posedge clk_i) disable iff (rst_i)
        enter_run |=> bit_times_left_r == $past(sof_period_bits_r)
                      && sof_sequence_count_r == $past(sof_sequence_count_r) + 16'h0001;
    endproperty
    a_enter: assert property (p_enter) else $error("entry reload wrong");

    property p_toggle_copy;
        @(posedge clk_i) disable iff (rst_i)
        reload && !enter_run |=> left_count_toggle_copy_r == $past(interval_update_toggle_r);
    endproperty
    a_toggle_copy: assert property (p_toggle_copy) else $error("toggle not copied");

    property p_seq_step;
        @(posedge clk_i) disable iff (rst_i)
        !frame_start |=> $stable(sof_sequence_count_r);
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("count moved off reload");

    property p_budget;
        @(posedge clk_i) disable iff (rst_i)
        frame_start |=> largest_packet_cnt_o == $past(largest_packet_bits_r);
    endproperty
    a_budget: assert property (p_budget) else $error("packet budget not loaded");

    property p_sca_order;
        @(posedge clk_i) disable iff (rst_i)
        st_r == ufc_pkg::ST_IDLE && frame_start
        |=> sof_token_o && !ed_fetch_ok_o ##1 sca_wr_req_o
            && sca_wr_data_o == sof_sequence_count_r;
    endproperty
    a_sca_order: assert property (p_sca_order) else $error("shared write order wrong");

    property p_sof_flag;
        @(posedge clk_i) disable iff (rst_i)
        sca_wr_req_o && sca_wr_ack_i |=> evt_status[ufc_pkg::EVT_SOF_BIT] && ed_fetch_ok_o;
    endproperty
    a_sof_flag: assert property (p_sof_flag) else $error("frame flag not set");

endmodule

/* File: shared/ufc_pkg.sv */
// Constants, types and helpers shared by the frame counter block.
package ufc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] OFF_PERIOD = 8'h00;
    localparam logic [7:0] OFF_LEFT = 8'h04;
    localparam logic [7:0] OFF_SEQ = 8'h08;
    localparam logic [7:0] OFF_EVT = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_CTRL = 8'h14;

    // ==========================================================
    // Field layout and reset values
    localparam int PERIOD_W = 14;
    localparam int LPKT_LSB = 16;
    localparam int LPKT_W = 15;
    localparam int TOGGLE_BIT = 31;
    localparam int SEQ_W = 16;
    localparam logic [13:0] PERIOD_RST = 14'h2EDF;
    localparam logic [14:0] LPKT_RST = 15'h0000;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_SRST_BIT = 1;
    localparam int EVT_W = 2;
    localparam int EVT_SOF_BIT = 0;
    localparam int EVT_WRAP_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int BIT_TIME_PS = 83333;
    localparam int BIT_TICK_CYC = BIT_TIME_PS / CLK_PERIOD_PS;
    localparam int TICK_W = 5;

    // ==========================================================
    // Frame sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SOF = 3'h2,
        ST_WR = 3'h4
    } ufc_frame_st_t;

    // Byte-lane merge of a bus write into an old word.
    function automatic logic [31:0] wmerge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

/* File: verilog/ufc_bit_tick.sv */
// Bit-time tick divider for the frame counter.
`timescale 1ns/1ps
module ufc_bit_tick (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Tick
    output logic tick_o
);

    logic [ufc_pkg::TICK_W-1:0] cnt_r;
    localparam logic [ufc_pkg::TICK_W-1:0] LAST = ufc_pkg::TICK_W'(ufc_pkg::BIT_TICK_CYC - 1);

    // The bit time is not a whole number of clocks; the period rounds down.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            tick_o <= 1'b0;
        end else if (cnt_r == LAST) begin
            cnt_r <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick_o <= 1'b0;
        end
    end

endmodule

/* File: verilog/ufc_evt_irq.sv */
// Sticky event flags, mask and interrupt line.
`timescale 1ns/1ps
module ufc_evt_irq (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Events and software access
    input wire logic [ufc_pkg::EVT_W-1:0] set_i,
    input wire logic clr_we_i,
    input wire logic [ufc_pkg::EVT_W-1:0] clr_i,
    input wire logic mask_we_i,
    input wire logic [ufc_pkg::EVT_W-1:0] mask_i,
    // State
    output logic [ufc_pkg::EVT_W-1:0] status_o,
    output logic [ufc_pkg::EVT_W-1:0] mask_o,
    output logic irq_o
);

    logic [ufc_pkg::EVT_W-1:0] status_nxt;
    logic [ufc_pkg::EVT_W-1:0] mask_nxt;

    // A new event outranks a clear written in the same cycle.
    always_comb begin
        status_nxt = (status_o & ~(clr_we_i ? clr_i : '0)) | set_i;
        mask_nxt = mask_we_i ? mask_i : mask_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_o <= '0;
            mask_o <= '0;
            irq_o <= 1'b0;
        end else begin
            status_o <= status_nxt;
            mask_o <= mask_nxt;
            irq_o <= |(status_nxt & mask_nxt);
        end
    end

    property p_set_wins;
        @(posedge clk_i) disable iff (rst_i)
        set_i[ufc_pkg::EVT_SOF_BIT] |=> status_o[ufc_pkg::EVT_SOF_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event flag lost");

endmodule

/* File: sim/ufc_sca_model.sv */
// Shared-area memory model that acknowledges frame count writes.
`timescale 1ns/1ps
module ufc_sca_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Shared-area write port
    input wire logic req_i,
    input wire logic [3:0] dly_i,
    output logic ack_o
);
    logic [3:0] wait_r;
    // ==========================================================
    // Latency
    // The ack is a single pulse dly_i + 1 cycles after the request; a slow memory keeps
    // the design waiting with its request raised.
    always_ff @(posedge clk_i) begin
        if (rst_i || !req_i) begin
            wait_r <= 4'h0;
            ack_o <= 1'b0;
        end else begin
            wait_r <= wait_r + 4'h1;
            ack_o <= !ack_o && (wait_r >= dly_i);
        end
    end
endmodule

/* File: sim/test_usb_host_frame_counter.sv */
// Register-level bench for the frame counter block.
`timescale 1ns/1ps
module test_usb_host_frame_counter;
    logic clk_i = 0, rst_i = 1, xfer_bit_i = 0, sca_wr_ack_i;
    logic s_axil_awvalid_i = 0, s_axil_wvalid_i = 0, s_axil_bready_i = 0;
    logic s_axil_arvalid_i = 0, s_axil_rready_i = 0;
    logic [7:0] s_axil_awaddr_i = 0, s_axil_araddr_i = 0;
    logic [31:0] s_axil_wdata_i = 0, s_axil_rdata_o, v, saved;
    logic [3:0] s_axil_wstrb_i = 0, dly = 4'h2;
    logic s_axil_awready_o, s_axil_wready_o, s_axil_bvalid_o, s_axil_arready_o;
    logic s_axil_rvalid_o, sof_token_o, sca_wr_req_o, ed_fetch_ok_o, irq_o;
    logic [1:0] s_axil_bresp_o, s_axil_rresp_o, rsp;
    logic [15:0] sca_wr_data_o;
    logic [14:0] largest_packet_cnt_o;
    int errors = 0, n_compared = 0, n;
    always #2 clk_i = ~clk_i;
    ufc_frame_counter dut_u (.clk_i, .rst_i, .s_axil_awaddr_i, .s_axil_awvalid_i,
        .s_axil_awready_o, .s_axil_wdata_i, .s_axil_wstrb_i, .s_axil_wvalid_i,
        .s_axil_wready_o, .s_axil_bresp_o, .s_axil_bvalid_o, .s_axil_bready_i,
        .s_axil_araddr_i, .s_axil_arvalid_i, .s_axil_arready_o, .s_axil_rdata_o,
        .s_axil_rresp_o, .s_axil_rvalid_o, .s_axil_rready_i, .xfer_bit_i, .sof_token_o,
        .sca_wr_req_o, .sca_wr_data_o, .sca_wr_ack_i, .ed_fetch_ok_o,
        .largest_packet_cnt_o, .irq_o);
    ufc_sca_model mem_u (.clk_i, .rst_i, .req_i(sca_wr_req_o), .dly_i(dly),
        .ack_o(sca_wr_ack_i));
    // ==========================================================
    // Checking and closing
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return sof_token_o;
            1: return sca_wr_req_o;
            default: return !sca_wr_req_o;
        endcase
    endfunction
    // Counts falling edges until the chosen condition holds.
    task automatic wait_hi(input int s, output int cnt);
        for (cnt = 0; cnt < 3000 && pick(s) !== 1'b1; cnt++) @(negedge clk_i);
        if (cnt >= 3000) begin
            errors++;
            give_verdict();
        end
    endtask
    // ==========================================================
    // AXI4-Lite master: ready is looked at on the falling edge, so the
    // release after the rising edge uses the value that edge really saw.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b, ha, hw, hb;
        int i;
        @(posedge clk_i);
        {aw, w, b} = 3'b111;
        s_axil_awaddr_i <= a;
        s_axil_wdata_i <= d;
        s_axil_wstrb_i <= 4'hF;
        {s_axil_awvalid_i, s_axil_wvalid_i, s_axil_bready_i} <= 3'b111;
        for (i = 0; i < 100 && (aw || w || b); i++) begin
            @(negedge clk_i);
            ha = aw && s_axil_awready_o;
            hw = w && s_axil_wready_o;
            hb = b && s_axil_bvalid_o;
            if (hb) rsp = s_axil_bresp_o;
            @(posedge clk_i);
            if (ha) s_axil_awvalid_i <= 0;
            if (hw) s_axil_wvalid_i <= 0;
            if (hb) s_axil_bready_i <= 0;
            {aw, w, b} = {aw && !ha, w && !hw, b && !hb};
        end
        if (i >= 100) begin
            errors++;
            give_verdict();
        end
    endtask
    task automatic rd(input logic [7:0] a);
        logic ar, r;
        int i;
        @(posedge clk_i);
        {ar, r} = 2'b11;
        s_axil_araddr_i <= a;
        {s_axil_arvalid_i, s_axil_rready_i} <= 2'b11;
        for (i = 0; i < 100 && r; i++) begin
            @(negedge clk_i);
            if (s_axil_rvalid_o) v = s_axil_rdata_o;
            if (s_axil_rvalid_o) rsp = s_axil_rresp_o;
            if (s_axil_rvalid_o) r = 0;
            @(posedge clk_i);
            if (ar && s_axil_arready_o) s_axil_arvalid_i <= 0;
            if (ar && s_axil_arready_o) ar = 0;
            if (!r) s_axil_rready_i <= 0;
        end
        if (i >= 100) begin
            errors++;
            give_verdict();
        end
    endtask
    // ==========================================================
    // Scenarios
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        repeat (2) @(posedge clk_i);
        rd(ufc_pkg::OFF_PERIOD); chk("period", v, 32'h0000_2EDF);
        chk("rresp", rsp, ufc_pkg::RESP_OKAY);
        rd(ufc_pkg::OFF_LEFT); chk("left", v, 32'h0000_0000);
        wr(ufc_pkg::OFF_LEFT, 32'hFFFF_FFFF); chk("bresp", rsp, ufc_pkg::RESP_OKAY);
        wr(ufc_pkg::OFF_SEQ, 32'hFFFF_FFFF);
        rd(ufc_pkg::OFF_LEFT); chk("left ro", v, 32'h0000_0000);
        rd(ufc_pkg::OFF_SEQ); chk("seq ro", v, 32'h0000_0000);
        wr(8'h18, 32'h0000_0001); chk("unmapped", rsp, ufc_pkg::RESP_SLVERR);
        rd(8'h18); chk("rd unmapped", rsp, ufc_pkg::RESP_SLVERR);
        chk("rd unmapped data", v, 32'h0000_0000);
        wr(ufc_pkg::OFF_PERIOD, 32'h8010_0005);
        wr(ufc_pkg::OFF_MASK, 32'h0000_0001);
        wr(ufc_pkg::OFF_CTRL, 32'h0000_0001);
        wait_hi(0, n);
        wait_hi(1, n);
        chk("sca data", sca_wr_data_o, 32'h0000_0001);
        chk("fetch early", ed_fetch_ok_o, 32'h0000_0000);
        wait_hi(2, n);
        chk("fetch ok", ed_fetch_ok_o, 32'h0000_0001);
        chk("budget", largest_packet_cnt_o, 32'h0000_0010);
        @(negedge clk_i);
        chk("irq", irq_o, 32'h0000_0001);
        repeat (3) begin
            @(posedge clk_i) xfer_bit_i <= 1;
            @(posedge clk_i) xfer_bit_i <= 0;
        end
        @(negedge clk_i);
        chk("budget use", largest_packet_cnt_o, 32'h0000_000D);
        wr(ufc_pkg::OFF_MASK, 32'h0000_0000);
        @(negedge clk_i);
        chk("irq masked", irq_o, 32'h0000_0000);
        wr(ufc_pkg::OFF_EVT, 32'h0000_0003);
        rd(ufc_pkg::OFF_EVT); chk("evt clear", v, 32'h0000_0000);
        dly <= 4'h9;
        wait_hi(0, n);
        @(negedge clk_i);
        wait_hi(0, n);
        chk("frame len", n, 6 * ufc_pkg::BIT_TICK_CYC - 1);
        wait_hi(1, n);
        chk("sca data 3", sca_wr_data_o, 32'h0000_0003);
        wait_hi(2, n);
        rd(ufc_pkg::OFF_SEQ); chk("seq", v, 32'h0000_0003);
        rd(ufc_pkg::OFF_EVT); chk("evt sof", v, 32'h0000_0001);
        rd(ufc_pkg::OFF_LEFT);
        chk("toggle copy", v & 32'hFFFF_C000, 32'h8000_0000);
        rd(ufc_pkg::OFF_PERIOD);
        saved = v;
        wr(ufc_pkg::OFF_CTRL, 32'h0000_0002);
        rd(ufc_pkg::OFF_PERIOD); chk("soft rst", v, 32'h8010_2EDF);
        rd(ufc_pkg::OFF_CTRL); chk("run cleared", v, 32'h0000_0000);
        wr(ufc_pkg::OFF_PERIOD, saved);
        rd(ufc_pkg::OFF_PERIOD); chk("restore", v, 32'h8010_0005);
        give_verdict();
    end
endmodule
